// >>> rtcis_pkg.sv
// package of constants and types for the rtc i2c slave register access block
package rtcis_pkg;
    // ************************************************
    // link and address constants
    // ************************************************
    localparam logic [6:0] RTCIS_SLAVE_ADDR = 7'h32; // fixed 7-bit address 0110010
    localparam int RTCIS_NUM_REGS = 16; // register bank depth
    localparam logic [3:0] RTCIS_ADDR_LAST = 4'hF; // pointer wraps after this
    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [3:0] RTCIS_OFS_EXTENSION = 4'hD; // extension register
    localparam logic [3:0] RTCIS_OFS_FLAGS = 4'hE; // flag register
    localparam logic [3:0] RTCIS_OFS_CONTROL_SETTINGS = 4'hF; // control_settings
    // ************************************************
    // field positions
    // ************************************************
    localparam int RTCIS_BIT_TEST = 7; // factory test bit in extension
    localparam int RTCIS_BIT_UPDATE = 5; // update_flag
    localparam int RTCIS_BIT_TIMER = 4; // timer_flag
    localparam int RTCIS_BIT_ALARM = 3; // alarm_flag
    localparam int RTCIS_BIT_LOWV = 1; // low_voltage_flag
    localparam int RTCIS_BIT_SUPDET = 0; // supply_detect_flag
    localparam logic [7:0] RTCIS_FLAG_W0_MASK = 8'h3B; // bits that only take a zero
    // ************************************************
    // reset values
    // ************************************************
    localparam logic [7:0] RTCIS_RST_REG = 8'h00; // undefined registers start at zero
    localparam logic [7:0] RTCIS_RST_FLAGS = 8'h02; // low_voltage_flag set
    localparam logic [7:0] RTCIS_READ_INVALID = 8'hFF; // read data after timeout
    // ************************************************
    // timing
    // ************************************************
    localparam longint RTCIS_CLK_HZ = 50000000; // system clock rate
    localparam longint RTCIS_TIMEOUT_MS = 950; // 0.95 s bus timeout in ms
    localparam longint RTCIS_TIMEOUT_CYC = RTCIS_CLK_HZ * RTCIS_TIMEOUT_MS / 1000;
    // ************************************************
    // types
    // ************************************************
    typedef enum logic [2:0]
    {
        RTCIS_IDLE = 3'b000, // waiting for start
        RTCIS_ADDR = 3'b001, // receiving address byte
        RTCIS_RX = 3'b010, // receiving data bytes
        RTCIS_TX = 3'b011, // sending data bytes
        RTCIS_ACK = 3'b100, // driving acknowledge
        RTCIS_MACK = 3'b101, // sampling master acknowledge
        RTCIS_WAIT = 3'b110 // released, waiting for stop
    } rtcis_state_t;

    // sampled bus levels
    typedef struct packed
    {
        logic scl;
        logic sda;
    } rtcis_bus_t;

    // open-drain data pin drive
    typedef struct packed
    {
        logic out;
        logic oe;
    } rtcis_sda_drv_t;
endpackage : rtcis_pkg

// >>> rtcis_slave.sv
// i2c slave giving a bus master byte access to the rtc register bank
`timescale 1ns/1ps
`default_nettype none
module rtcis_slave
    import rtcis_pkg::*;
#(
    parameter longint TIMEOUT_CYC = RTCIS_TIMEOUT_CYC // bus timeout in clock cycles
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    output var logic busy,
    output var logic [7:0] control_settings
);
    import rtcis_pkg::*;

    // ************************************************
    // elaboration checks
    // ************************************************
    if (TIMEOUT_CYC < 16 || TIMEOUT_CYC >= 64'd1 << 32)
    begin : g_bad_timeout
        $error("timeout count out of range");
    end

    // ************************************************
    // pin synchronisers
    // ************************************************
    rtcis_bus_t sync1_reg; // first stage, read only by second
    rtcis_bus_t sync2_reg; // second stage
    rtcis_bus_t prev_reg; // previous sampled level for edges

    // two flip-flops ahead of all logic
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= '{scl: 1'b1, sda: 1'b1};
            sync2_reg <= '{scl: 1'b1, sda: 1'b1};
            prev_reg <= '{scl: 1'b1, sda: 1'b1};
        end
        else
        begin
            sync1_reg <= '{scl: scl_in, sda: sda_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // bus events from the synchronised levels
    logic scl_rise; // scl rising edge
    logic scl_fall; // scl falling edge
    logic start_det; // start or restart
    logic stop_det; // stop
    assign scl_rise = sync2_reg.scl && !prev_reg.scl;
    assign scl_fall = !sync2_reg.scl && prev_reg.scl;
    assign start_det = sync2_reg.scl && prev_reg.scl && prev_reg.sda && !sync2_reg.sda;
    assign stop_det = sync2_reg.scl && prev_reg.scl && !prev_reg.sda && sync2_reg.sda;

    // ************************************************
    // state
    // ************************************************
    rtcis_state_t state_reg, state_next; // protocol state
    logic [3:0] bit_cnt_reg, bit_cnt_next; // bits of the current byte
    logic [7:0] shift_reg, shift_next; // byte shifter
    logic [3:0] ptr_reg, ptr_next; // register pointer
    logic rd_reg, rd_next; // transaction direction is read
    logic ptr_set_reg, ptr_set_next; // pointer byte already taken
    logic active_reg, active_next; // inside start..stop
    logic dead_reg, dead_next; // timed out, bus invalid until start
    logic [31:0] tmo_reg, tmo_next; // timeout counter
    logic sda_drv_reg, sda_drv_next; // pull sda low
    logic [7:0] regs_reg [RTCIS_NUM_REGS]; // register bank
    logic wr_en; // write one byte into the bank
    logic [7:0] wr_data; // byte to write
    logic [3:0] wr_addr; // where to write
    rtcis_sda_drv_t drv; // pin drive bundle

    // next-state logic
    always_comb
    begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rd_next = rd_reg;
        ptr_set_next = ptr_set_reg;
        active_next = active_reg;
        dead_next = dead_reg;
        tmo_next = tmo_reg;
        sda_drv_next = sda_drv_reg;
        wr_en = 1'b0;
        wr_data = shift_reg;
        wr_addr = ptr_reg;
        // timeout counts from start to stop
        if (active_reg)
        begin
            tmo_next = tmo_reg + 32'h00000001;
        end
        if (start_det)
        begin
            // restart handled the same as start, except the running timeout count is kept
            state_next = RTCIS_ADDR;
            bit_cnt_next = 4'h0;
            sda_drv_next = 1'b0;
            ptr_set_next = 1'b0;
            dead_next = 1'b0;
            if (!active_reg)
            begin
                tmo_next = 32'h00000000;
            end
            active_next = 1'b1;
        end
        else if (stop_det)
        begin
            // stop ends everything and releases sda
            state_next = RTCIS_IDLE;
            sda_drv_next = 1'b0;
            active_next = 1'b0;
            tmo_next = 32'h00000000;
        end
        else if (active_reg && tmo_reg >= TIMEOUT_CYC[31:0] - 32'h00000001)
        begin
            // bus clearing back to standby
            state_next = RTCIS_IDLE;
            sda_drv_next = 1'b0;
            active_next = 1'b0;
            dead_next = 1'b1;
            tmo_next = 32'h00000000;
        end
        else
        begin
            case (state_reg)
                RTCIS_ADDR, RTCIS_RX:
                begin
                    // sample on rising scl
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sync2_reg.sda};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == 4'h8)
                    begin
                        bit_cnt_next = 4'h0;
                        if (state_reg == RTCIS_ADDR)
                        begin
                            if (shift_reg[7:1] == RTCIS_SLAVE_ADDR)
                            begin
                                rd_next = shift_reg[0];
                                sda_drv_next = 1'b1;
                                state_next = RTCIS_ACK;
                            end
                            else
                            begin
                                state_next = RTCIS_WAIT;
                            end
                        end
                        else
                        begin
                            sda_drv_next = 1'b1;
                            state_next = RTCIS_ACK;
                            if (!ptr_set_reg)
                            begin
                                ptr_next = shift_reg[3:0];
                                ptr_set_next = 1'b1;
                            end
                            else
                            begin
                                wr_en = !dead_reg;
                                ptr_next = ptr_reg + 4'h1;
                            end
                        end
                    end
                end
                RTCIS_ACK:
                begin
                    // release at ninth fall, then next byte
                    if (scl_fall)
                    begin
                        sda_drv_next = 1'b0;
                        bit_cnt_next = 4'h0;
                        if (rd_reg)
                        begin
                            shift_next = regs_reg[ptr_reg];
                            sda_drv_next = !regs_reg[ptr_reg][7];
                            state_next = RTCIS_TX;
                        end
                        else
                        begin
                            state_next = RTCIS_RX;
                        end
                    end
                end
                RTCIS_TX:
                begin
                    // shift out on falling scl
                    if (scl_fall)
                    begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7)
                        begin
                            sda_drv_next = 1'b0;
                            ptr_next = ptr_reg + 4'h1;
                            state_next = RTCIS_MACK;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b1};
                            sda_drv_next = !shift_reg[6];
                        end
                    end
                end
                RTCIS_MACK:
                begin
                    // master ack sampled on ninth rise
                    if (scl_rise)
                    begin
                        if (sync2_reg.sda)
                        begin
                            state_next = RTCIS_WAIT;
                        end
                        else
                        begin
                            state_next = RTCIS_ACK;
                        end
                    end
                end
                default:
                begin
                    sda_drv_next = 1'b0;
                end
            endcase
        end
        if (wr_en)
        begin
            wr_data = shift_reg;
        end
    end

    // protocol registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= RTCIS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 4'h0;
            rd_reg <= 1'b0;
            ptr_set_reg <= 1'b0;
            active_reg <= 1'b0;
            dead_reg <= 1'b0;
            tmo_reg <= 32'h00000000;
            sda_drv_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rd_reg <= rd_next;
            ptr_set_reg <= ptr_set_next;
            active_reg <= active_next;
            dead_reg <= dead_next;
            tmo_reg <= tmo_next;
            sda_drv_reg <= sda_drv_next;
        end
    end

    // ************************************************
    // register bank
    // ************************************************
    // one register per entry, flag bits only take zeros
    for (genvar i = 0; i < RTCIS_NUM_REGS; i++)
    begin : g_regs
        logic [7:0] bank_next; // next value of this entry
        always_comb
        begin
            bank_next = regs_reg[i];
            if (wr_en && wr_addr == 4'(i))
            begin
                if (4'(i) == RTCIS_OFS_FLAGS)
                begin
                    bank_next = (wr_data & ~RTCIS_FLAG_W0_MASK)
                        | (regs_reg[i] & wr_data & RTCIS_FLAG_W0_MASK);
                end
                else
                begin
                    bank_next = wr_data;
                end
            end
        end
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                regs_reg[i] <= (4'(i) == RTCIS_OFS_FLAGS) ? RTCIS_RST_FLAGS : RTCIS_RST_REG;
            end
            else
            begin
                regs_reg[i] <= bank_next;
            end
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    logic busy_reg; // transaction in progress
    logic [7:0] ctrl_reg; // copy of control_settings
    // open-drain data, read of dead bus gives all ones by never pulling low
    always_comb
    begin
        drv.out = 1'b0;
        drv.oe = sda_drv_next && !(dead_next && state_next == RTCIS_TX);
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            busy_reg <= 1'b0;
            ctrl_reg <= RTCIS_RST_REG;
        end
        else
        begin
            sda_out <= drv.out;
            sda_oe <= drv.oe;
            busy_reg <= active_next;
            ctrl_reg <= regs_reg[RTCIS_OFS_CONTROL_SETTINGS];
        end
    end
    assign busy = busy_reg;
    assign control_settings = ctrl_reg;
endmodule : rtcis_slave
`default_nettype wire

// >>> rtcis_slave_chk.sv
// assertion checker watching the ports of the rtc i2c slave
`timescale 1ns/1ps
`default_nettype none
module rtcis_slave_chk
    import rtcis_pkg::*;
#(
    parameter longint TIMEOUT_CYC = RTCIS_TIMEOUT_CYC // bus timeout in clock cycles
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy,
    input wire logic [7:0] control_settings
);
    logic [31:0] busy_cnt_reg; // cycles busy has stood
    logic [31:0] busy_cnt_next;
    // ****************************************
    // busy length counter
    // ****************************************
    always_comb
    begin
        busy_cnt_next = busy ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_cnt_next;
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    property p_drive_low;
        sda_oe |-> sda_out == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("data pin driven high");
    // sync lag allowed: clock was low three cycles before any change
    property p_oe_scl_low;
        $changed(sda_oe) |-> !$past(scl_in, 3);
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved in clock high");
    property p_start_busy;
        $fell(sda_in) && scl_in && $past(scl_in, 2) |-> ##[1:8] busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken");
    property p_stop_idle;
        $rose(sda_in) && scl_in && $past(scl_in, 2) && !sda_oe |-> ##[1:8] !busy;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");
    property p_stop_quiet;
        $rose(sda_in) && scl_in && $past(scl_in, 2) |=> !sda_oe [*8];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
    property p_start_quiet;
        $fell(sda_in) && scl_in && $past(scl_in, 2) |=> !sda_oe [*8];
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("drive in address");
    property p_idle_quiet;
        (!busy) [*3] |-> !sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
    property p_timeout;
        busy_cnt_reg <= 32'(TIMEOUT_CYC + 8);
    endproperty
    a_timeout: assert property (p_timeout) else $error("bus timeout missed");
    property p_ctl_bus_only;
        $changed(control_settings) |-> $past(busy);
    endproperty
    a_ctl_bus_only: assert property (p_ctl_bus_only) else $error("register moved idle");
endmodule : rtcis_slave_chk
bind rtcis_slave rtcis_slave_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u
(
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .busy(busy),
    .control_settings(control_settings)
);
`default_nettype wire

// >>> rtcis_master.sv
// bus master model driving the two-wire link of the slave
`timescale 1ns/1ps
`default_nettype none
module rtcis_master
(
    output var logic scl,
    output var logic sda_pull,
    input wire logic sda_line
);
    localparam time TQ = 40ns; // quarter of the 160 ns link period
    localparam time TBUF = 1300ns; // idle between stop and start
    // idle bus: clock high, data released
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one pulse: data set in low phase, sampled in high phase
    task automatic clk_bit(input logic b, output logic r);
        sda_pull = ~b;
        #TQ;
        scl = 1'b1;
        #TQ;
        r = sda_line;
        #TQ;
        scl = 1'b0;
        #TQ;
    endtask : clk_bit
    // start or restart; low phase stretched until the ack is gone
    task automatic start_cond();
        sda_pull = 1'b0;
        #(3 * TQ);
        scl = 1'b1;
        #TQ;
        sda_pull = 1'b1;
        #TQ;
        scl = 1'b0;
        #TQ;
    endtask : start_cond
    // stop, then hold the bus idle
    task automatic stop_cond();
        sda_pull = 1'b1;
        #(2 * TQ);
        scl = 1'b1;
        #TQ;
        sda_pull = 1'b0;
        #TBUF;
    endtask : stop_cond
    // byte out, msb first, ack sampled on ninth pulse
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], r);
        clk_bit(1'b1, ack);
        #(2 * TQ);
    endtask : send_byte
    // byte in; ack low unless last
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, b[i]);
        clk_bit(last, r);
        sda_pull = 1'b0;
        #TQ; // keeps the next data or stop change in a later time step
    endtask : recv_byte
endmodule : rtcis_master
`default_nettype wire

// >>> rtcis_slave_tb.sv
// self-checking bench for the rtc i2c slave
`timescale 1ns/1ps
`default_nettype none
module rtcis_slave_tb;
    import rtcis_pkg::*;
    localparam longint TMO = 2000; // shortened bus timeout
    logic clk; // system clock
    logic rst; // async reset
    logic scl; // link clock from master
    logic m_pull; // master pulls data low
    wire sda; // wired data line with pull-up
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic [7:0] control_settings;
    logic [7:0] got; // byte read back
    logic ack; // acknowledge seen
    logic [7:0] bad [4] = '{8'h66, 8'h67, 8'hE4, 8'h24}; // foreign addresses
    int fails;
    int check_count;
    // low when either party pulls
    assign sda = !(sda_oe && !sda_out) && !m_pull;
    always #10 clk = ~clk;
    rtcis_slave #(.TIMEOUT_CYC(TMO)) dut_u
    (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .busy(busy), .control_settings(control_settings)
    );
    rtcis_master mst_u (.scl(scl), .sda_pull(m_pull), .sda_line(sda));
    // ****************************************
    // compare and transfer tasks
    // ****************************************
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte
    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic addr_phase(input logic [7:0] a, input logic e);
        mst_u.start_cond();
        mst_u.send_byte(a, ack);
        chk_bit("address ack", e, ack);
    endtask : addr_phase
    // pointer, then n data bytes
    task automatic write_regs(input logic [7:0] p, input int n, input logic [7:0] d0,
        input logic [7:0] d1);
        addr_phase(8'h64, 1'b0);
        mst_u.send_byte(p, ack);
        chk_bit("pointer ack", 1'b0, ack);
        for (int i = 0; i < n; i++)
        begin
            mst_u.send_byte(i == 0 ? d0 : d1, ack);
            chk_bit("data ack", 1'b0, ack);
        end
        mst_u.stop_cond();
    endtask : write_regs
    // pointer, restart, n bytes read, last not acked
    task automatic read_regs(input logic [7:0] p, input int n, input logic [7:0] e0,
        input logic [7:0] e1);
        addr_phase(8'h64, 1'b0);
        mst_u.send_byte(p, ack);
        addr_phase(8'h65, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            mst_u.recv_byte(i == n - 1, got);
            chk_byte("read data", i == 0 ? e0 : e1, got);
        end
        mst_u.stop_cond();
    endtask : read_regs
    task automatic end_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, fails);
    endtask : end_test
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        fails = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk_byte("control_settings", RTCIS_RST_REG, control_settings);
        read_regs({4'h0, RTCIS_OFS_EXTENSION}, 2, RTCIS_RST_REG, RTCIS_RST_FLAGS);
        end_test("reset");
        write_regs(8'h07, 1, 8'hA5, 8'h00);
        write_regs(8'h07, 0, 8'h00, 8'h00);
        addr_phase(8'h65, 1'b0);
        mst_u.recv_byte(1'b1, got);
        chk_byte("ram", 8'hA5, got);
        mst_u.stop_cond();
        end_test("ram");
        write_regs({4'h0, RTCIS_OFS_EXTENSION}, 1, 8'h00, 8'h00);
        write_regs({4'h0, RTCIS_OFS_FLAGS}, 1, RTCIS_FLAG_W0_MASK, 8'h00);
        read_regs({4'h0, RTCIS_OFS_FLAGS}, 1, RTCIS_RST_FLAGS, 8'h00);
        write_regs({4'h0, RTCIS_OFS_FLAGS}, 1, 8'h00, 8'h00);
        read_regs({4'h0, RTCIS_OFS_FLAGS}, 1, 8'h00, 8'h00);
        end_test("flags");
        write_regs({4'h0, RTCIS_OFS_CONTROL_SETTINGS}, 2, 8'hC8, 8'h12);
        chk_byte("control_settings", 8'hC8, control_settings);
        read_regs({4'h0, RTCIS_OFS_CONTROL_SETTINGS}, 2, 8'hC8, 8'h12);
        end_test("wrap");
        foreach (bad[i])
        begin
            addr_phase(bad[i], 1'b1);
            mst_u.stop_cond();
        end
        chk_bit("busy", 1'b0, busy);
        end_test("address");
        addr_phase(8'h65, 1'b0);
        mst_u.recv_byte(1'b0, got);
        chk_bit("busy", 1'b1, busy);
        repeat (TMO + 100) @(posedge clk);
        #1;
        chk_bit("busy", 1'b0, busy);
        mst_u.recv_byte(1'b1, got);
        chk_byte("timeout read", RTCIS_READ_INVALID, got);
        mst_u.stop_cond();
        addr_phase(8'h64, 1'b0);
        mst_u.send_byte(8'h07, ack);
        repeat (TMO + 100) @(posedge clk);
        #1;
        mst_u.send_byte(8'h5A, ack);
        chk_bit("dead ack", 1'b1, ack);
        mst_u.stop_cond();
        read_regs(8'h07, 1, 8'hA5, 8'h00);
        end_test("timeout");
        print_verdict();
    end
    // hang guard
    initial
    begin
        #500000;
        fails++;
        $display("ERROR watchdog expected done seen hang");
        print_verdict();
    end
endmodule : rtcis_slave_tb
`default_nettype wire
